// File: verilog/clock_manager_regs.vh
`ifndef CLOCK_MANAGER_REGS_VH
`define CLOCK_MANAGER_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CM_CTRL_OFS        8'h00
`define CM_PHASE_INIT_OFS  8'h04
`define CM_IN_PERIOD_OFS   8'h08
`define CM_SYN_PERIOD_OFS  8'h0C
`define CM_STATUS_OFS      8'h10
`define CM_PHASE_OFS       8'h14

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define CM_CTRL_SOFT_RST   0
`define CM_CTRL_PH_LO      1
`define CM_CTRL_PH_HI      2
`define CM_CTRL_FB_LO      3
`define CM_CTRL_FB_HI      4
`define CM_CTRL_FB_2X      5
`define CM_CTRL_UNIT_USED  6
`define CM_CTRL_W          7

// phase offset modes
`define CM_PH_NONE         2'h0
`define CM_PH_FIXED        2'h1
`define CM_PH_VARIABLE     2'h2
// feedback modes
`define CM_FB_NONE         2'h0
`define CM_FB_INTERNAL     2'h1
`define CM_FB_EXTERNAL     2'h2

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define CM_ST_CFG_ERR      0
`define CM_ST_IN_STOP      1
`define CM_ST_SYN_STOP     2
`define CM_ST_LOCKED       8
`define CM_ST_TAP_LO       16
`define CM_ST_TAP_HI       23

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CM_CTRL_RST        7'h00
`define CM_PHASE_INIT_RST  8'h00
`define CM_IN_PERIOD_RST   16'h0010
`define CM_SYN_PERIOD_RST  16'h0010

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CM_CLK_MHZ         25
`define CM_STOP_LOCK_MS    100
`define CM_STOP_LOCK_CYC   (`CM_STOP_LOCK_MS * 1000 * `CM_CLK_MHZ)
`define CM_LOCK_EDGES      4096
`define CM_RST_MIN_CYC     3
`define CM_LOCK_DROP_CYC   4

`endif

// File: verilog/clock_manager_lock_reset_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "clock_manager_regs.vh"

//Function
// - lock rises only with healthy input clock
// - input-stopped bit after one missed cycle
// - lock may persist until 100 ms stop
// - input-stopped bit clears when clock resumes
// - synthesizer-stopped bit when synthesized clock stops
// - asynchronous reset restores post-configuration state
// - reset drops lock within four cycles
// - reset returns delay tap to zero
// - reset restores initial phase offset
// - phase stepping only in variable mode
// - feedback none, internal or external source
// - lock low after configuration and in reset
// - no self relock after lock lost
module clock_manager_lock_reset_monitor #(
   parameter STOP_LOCK_CYCLES = `CM_STOP_LOCK_CYC,
   parameter LOCK_EDGES = `CM_LOCK_EDGES
) (
   // bus clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // manager clocks, sampled on hclk
   input wire input_clock,
   input wire feedback_clock,
   input wire synthesized_clock,
   // manager reset, active high
   input wire manager_reset,
   // variable phase stepping
   input wire phase_step_clock,
   input wire phase_step_enable,
   input wire phase_step_direction,
   output reg phase_step_done,
   // supervision outputs
   output reg locked,
   output reg [2:0] status,
   output reg unit_rate_output,
   output reg [7:0] delay_tap,
   output reg [7:0] phase_value
);

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_ACQUIRE = 3'b001;
   localparam [2:0] ST_LOCKED = 3'b010;
   localparam [2:0] ST_LOST = 3'b100;

   localparam [21:0] STOP_LIMIT = STOP_LOCK_CYCLES[21:0];
   localparam [12:0] LOCK_LIMIT = LOCK_EDGES[12:0];

   // ----------------------------------------------------------------------
   // bus registers
   // ----------------------------------------------------------------------
   reg [`CM_CTRL_W-1:0] ctrl;
   reg [7:0] phase_init;
   reg [15:0] in_period;
   reg [15:0] syn_period;
   reg wr_pend;
   reg [7:0] wr_addr;
   wire addr_phase;
   wire [31:0] status_word;
   reg [31:0] next_rdata;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & htrans[1] & hready;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase & hwrite;
         wr_addr <= haddr;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `CM_CTRL_RST;
         phase_init <= `CM_PHASE_INIT_RST;
         in_period <= `CM_IN_PERIOD_RST;
         syn_period <= `CM_SYN_PERIOD_RST;
      end else if (wr_pend) begin
         case (wr_addr)
            `CM_CTRL_OFS: begin
               ctrl <= hwdata[`CM_CTRL_W-1:0];
            end
            `CM_PHASE_INIT_OFS: begin
               phase_init <= hwdata[7:0];
            end
            `CM_IN_PERIOD_OFS: begin
               in_period <= hwdata[15:0];
            end
            `CM_SYN_PERIOD_OFS: begin
               syn_period <= hwdata[15:0];
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   assign status_word = {8'h00, delay_tap, 7'h00, locked, 5'h00, status};

   // read data is registered in the address phase; unmapped offsets read zero
   always @* begin
      next_rdata = 32'h0000_0000;
      case (haddr)
         `CM_CTRL_OFS: next_rdata = {25'h000_0000, ctrl};
         `CM_PHASE_INIT_OFS: next_rdata = {24'h00_0000, phase_init};
         `CM_IN_PERIOD_OFS: next_rdata = {16'h0000, in_period};
         `CM_SYN_PERIOD_OFS: next_rdata = {16'h0000, syn_period};
         `CM_STATUS_OFS: next_rdata = status_word;
         `CM_PHASE_OFS: next_rdata = {24'h00_0000, phase_value};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase & ~hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // manager reset
   // ----------------------------------------------------------------------
   // the pin and the soft reset bit both clear the manager at once; both come
   // from clean sources, so using them as an asynchronous clear is safe
   wire mgr_rst_n;
   assign mgr_rst_n = hresetn & ~manager_reset & ~ctrl[`CM_CTRL_SOFT_RST];

   wire [1:0] ph_mode;
   wire [1:0] fb_mode;
   assign ph_mode = ctrl[`CM_CTRL_PH_HI:`CM_CTRL_PH_LO];
   assign fb_mode = ctrl[`CM_CTRL_FB_HI:`CM_CTRL_FB_LO];

   // ----------------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------------
   reg in_q;
   reg fb_q;
   reg syn_q;
   reg ps_q;
   wire in_rise;
   wire fb_rise;
   wire syn_rise;
   wire ps_rise;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_q <= 1'b0;
         fb_q <= 1'b0;
         syn_q <= 1'b0;
         ps_q <= 1'b0;
         unit_rate_output <= 1'b0;
      end else begin
         in_q <= input_clock;
         fb_q <= feedback_clock;
         syn_q <= synthesized_clock;
         ps_q <= phase_step_clock;
         unit_rate_output <= input_clock;
      end
   end

   assign in_rise = input_clock & ~in_q;
   assign fb_rise = feedback_clock & ~fb_q;
   assign syn_rise = synthesized_clock & ~syn_q;
   assign ps_rise = phase_step_clock & ~ps_q;

   // ----------------------------------------------------------------------
   // stopped-clock watchdogs
   // ----------------------------------------------------------------------
   // not sticky: each bit falls on the next edge of its clock
   reg [15:0] in_gap;
   reg [15:0] syn_gap;
   reg [21:0] in_stop;
   wire in_missed;
   wire syn_missed;

   assign in_missed = (in_gap > in_period);
   assign syn_missed = (syn_gap > syn_period);

   always @(posedge hclk or negedge mgr_rst_n) begin
      if (!mgr_rst_n) begin
         in_gap <= 16'h0000;
         syn_gap <= 16'h0000;
         in_stop <= 22'h00_0000;
         status <= 3'h0;
      end else begin
         if (in_rise) begin
            in_gap <= 16'h0000;
            in_stop <= 22'h00_0000;
         end else begin
            if (in_gap != 16'hFFFF) begin
               in_gap <= in_gap + 16'h0001;
            end
            if (in_stop != STOP_LIMIT) begin
               in_stop <= in_stop + 22'h00_0001;
            end
         end
         if (syn_rise) begin
            syn_gap <= 16'h0000;
         end else if (syn_gap != 16'hFFFF) begin
            syn_gap <= syn_gap + 16'h0001;
         end
         status[`CM_ST_IN_STOP] <= in_missed & ~in_rise;
         status[`CM_ST_SYN_STOP] <= syn_missed & ~syn_rise;
         // no feedback is legal only when just the synthesized outputs are used
         status[`CM_ST_CFG_ERR] <= (fb_mode == `CM_FB_NONE) & ctrl[`CM_CTRL_UNIT_USED];
      end
   end

   // ----------------------------------------------------------------------
   // lock state machine
   // ----------------------------------------------------------------------
   reg [2:0] state;
   reg [12:0] lock_cnt;
   reg fb_odd;
   wire fb_aligned;
   wire fb_seen;

   // a double-rate source gives two feedback edges per input edge; only the
   // one that should meet the input edge is compared
   assign fb_seen = fb_rise & (~ctrl[`CM_CTRL_FB_2X] | ~fb_odd);
   assign fb_aligned = (fb_mode == `CM_FB_NONE) | (in_rise & fb_seen);

   always @(posedge hclk or negedge mgr_rst_n) begin
      if (!mgr_rst_n) begin
         state <= ST_ACQUIRE;
         locked <= 1'b0;
         lock_cnt <= 13'h0000;
         delay_tap <= 8'h00;
         fb_odd <= 1'b0;
      end else begin
         if (fb_rise) begin
            fb_odd <= ~fb_odd;
         end
         case (state)
            ST_ACQUIRE: begin
               locked <= 1'b0;
               if (in_rise) begin
                  if (fb_aligned) begin
                     lock_cnt <= lock_cnt + 13'h0001;
                  end else begin
                     // walk the delay line until the edges meet
                     lock_cnt <= 13'h0000;
                     delay_tap <= delay_tap + 8'h01;
                  end
               end
               if (lock_cnt == LOCK_LIMIT) begin
                  state <= ST_LOCKED;
                  locked <= 1'b1;
               end
            end
            ST_LOCKED: begin
               // a brief stop keeps lock; only a long one drops it
               if (in_stop == STOP_LIMIT) begin
                  state <= ST_LOST;
                  locked <= 1'b0;
               end
            end
            ST_LOST: begin
               locked <= 1'b0;
            end
            default: begin
               state <= ST_ACQUIRE;
               locked <= 1'b0;
            end
         endcase
      end
   end
   // reset clears lock asynchronously, well inside the allowed window

   // ----------------------------------------------------------------------
   // phase offset
   // ----------------------------------------------------------------------
   reg phase_loaded;

   always @(posedge hclk or negedge mgr_rst_n) begin
      if (!mgr_rst_n) begin
         phase_value <= 8'h00;
         phase_loaded <= 1'b0;
         phase_step_done <= 1'b0;
      end else begin
         phase_step_done <= 1'b0;
         if (!phase_loaded) begin
            // first clock after reset picks up the configured start value, or zero in the no-offset mode
            phase_loaded <= 1'b1;
            phase_value <= (ph_mode == `CM_PH_NONE) ? 8'h00 : phase_init;
         end else if (ph_mode == `CM_PH_FIXED) begin
            phase_value <= phase_init;
         end else if (ph_mode == `CM_PH_VARIABLE && ps_rise && phase_step_enable) begin
            if (phase_step_direction) begin
               phase_value <= phase_value + 8'h01;
            end else begin
               phase_value <= phase_value - 8'h01;
            end
            phase_step_done <= 1'b1;
         end
      end
   end

endmodule // clock_manager_lock_reset_monitor

`default_nettype wire

// File: verification/clock_manager_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// lock and reset supervision checks
// ---------------------------------------------
module clock_manager_chk #(
   parameter STOP_LOCK_CYCLES = 200,
   parameter LOCK_EDGES = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // manager pins
   input wire logic input_clock,
   input wire logic synthesized_clock,
   input wire logic manager_reset,
   input wire logic phase_step_done,
   input wire logic locked,
   input wire logic [2:0] status,
   input wire logic [7:0] delay_tap,
   input wire logic [7:0] phase_value
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // lock lost outside a reset; only a manager reset or hresetn may clear it
   logic lost;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lost <= 1'b0;
      end else if (manager_reset) begin
         lost <= 1'b0;
      end else if ($fell(locked)) begin
         lost <= 1'b1;
      end
   end
   sequence s_step_taken;
      phase_step_done && phase_value != $past(phase_value);
   endsequence
   sequence s_step_over;
      ##1 !phase_step_done;
   endsequence
   chk_reset_unlocks: assert property (manager_reset |-> !locked)
      else $error("lock high during manager reset");
   chk_reset_clears: assert property (manager_reset |-> status[2:1] == 2'b00)
      else $error("status kept through manager reset");
   chk_tap_zero: assert property (manager_reset |-> delay_tap == 8'h00)
      else $error("delay tap not zero in reset");
   chk_input_resume: assert property ($rose(input_clock) |-> ##[1:3] !status[1])
      else $error("input stopped bit kept after clock resumed");
   chk_syn_stopped: assert property ($rose(status[2]) |-> $stable(synthesized_clock))
      else $error("synthesizer stop flagged while toggling");
   chk_lock_healthy: assert property ($rose(locked) |-> !status[1])
      else $error("lock rose with input stopped");
   chk_lock_stop: assert property ($fell(locked) && !manager_reset |-> status[1])
      else $error("lock fell with input running");
   chk_no_relock: assert property (lost |-> !locked)
      else $error("lock regained without reset");
   chk_step_moves: assert property (phase_step_done |-> s_step_taken)
      else $error("step done without phase change");
   chk_done_pulse: assert property (phase_step_done |-> s_step_over)
      else $error("step done longer than one cycle");
endmodule // clock_manager_chk
bind clock_manager_lock_reset_monitor clock_manager_chk #(
   .STOP_LOCK_CYCLES(STOP_LOCK_CYCLES),
   .LOCK_EDGES(LOCK_EDGES)
) chk (.hclk, .hresetn, .input_clock, .synthesized_clock, .manager_reset,
   .phase_step_done, .locked, .status, .delay_tap, .phase_value);
`default_nettype wire

// File: verification/relock_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// user relock monitor
// ---------------------------------------------
module relock_partner (
   // clock
   input wire logic hclk,
   // manager side
   input wire logic locked,
   input wire logic syn_stopped,
   input wire logic app_reset,
   output logic manager_reset
);
   // starts asserted: the manager is held until the input clock is up
   logic [3:0] hold = 4'hc;
   // twelve bus cycles cover more than three input clock cycles
   always @(posedge hclk) begin
      if (!locked && syn_stopped) begin
         hold <= 4'hc;
      end else if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end
   end
   assign manager_reset = app_reset | (hold != 4'h0);
endmodule // relock_partner
`default_nettype wire

// File: verification/clock_manager_lock_reset_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// bench
// ---------------------------------------------
module clock_manager_lock_reset_monitor_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, app_reset = 1'b0, in_run = 1'b1, syn_run = 1'b1;
   logic input_clock = 1'b0, synthesized_clock = 1'b0;
   logic phase_step_clock = 1'b0, phase_step_enable = 1'b0, phase_step_direction = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, locked, phase_step_done, manager_reset, unit_rate_output;
   wire logic [2:0] status;
   wire logic [7:0] delay_tap, phase_value;
   int n_fail = 0, n_checks = 0, n_done = 0, i;
   clock_manager_lock_reset_monitor #(.STOP_LOCK_CYCLES(200), .LOCK_EDGES(8)) DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .input_clock,
      .feedback_clock(input_clock), .synthesized_clock, .manager_reset,
      .phase_step_clock, .phase_step_enable, .phase_step_direction, .phase_step_done,
      .locked, .status, .unit_rate_output, .delay_tap, .phase_value);
   relock_partner partner (.hclk, .locked, .syn_stopped(status[2]), .app_reset,
      .manager_reset);
   initial begin
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      input_clock <= in_run ? ~input_clock : input_clock;
      synthesized_clock <= syn_run ? ~synthesized_clock : synthesized_clock;
      n_done <= n_done + (phase_step_done === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
         input logic [31:0] exp);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      if (!w) check(hrdata, exp);
      check({31'h0, hresp}, 32'h0000_0000);
   endtask
   task automatic step(input logic dir);
      @(posedge hclk);
      {phase_step_clock, phase_step_enable, phase_step_direction} <= {2'b11, dir};
      repeat (2) @(posedge hclk);
      {phase_step_clock, phase_step_enable} <= 2'b00;
      repeat (3) @(posedge hclk);
   endtask
   task automatic pulse_reset;
      app_reset <= 1'b1;
      repeat (2) @(posedge hclk);
      check({locked, delay_tap}, 9'h000);
      repeat (8) @(posedge hclk);
      app_reset <= 1'b0;
   endtask
   task automatic wait_lock;
      for (i = 0; i < 300 && locked !== 1'b1; i++) @(posedge hclk);
      check(locked, 1'b1);
   endtask
   task automatic test_done;
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      bus(8'h08, 1'b0, 0, 32'h0000_0010);
      bus(8'h0C, 1'b0, 0, 32'h0000_0010);
      bus(8'h18, 1'b1, 32'hFFFF_FFFF, 0);
      bus(8'h18, 1'b0, 0, 32'h0000_0000);
      check(locked, 1'b0);
      bus(8'h04, 1'b1, 32'h0000_0020, 0);
      bus(8'h00, 1'b1, 32'h0000_0004, 0);
      @(posedge hclk);
      pulse_reset();
      repeat (2) @(posedge hclk);
      check(phase_value, 8'h20);
      wait_lock();
      step(1'b1);
      check(phase_value, 8'h21);
      step(1'b0);
      step(1'b0);
      check({n_done[7:0], phase_value}, 16'h031F);
      bus(8'h00, 1'b1, 32'h0000_0002, 0);
      step(1'b1);
      check({n_done[7:0], phase_value}, 16'h0320);
      in_run <= 1'b0;
      repeat (20) @(posedge hclk);
      check({locked, status[1]}, 2'b11);
      bus(8'h10, 1'b0, 0, 32'h0000_0102);
      in_run <= 1'b1;
      repeat (4) @(posedge hclk);
      check(status[1], 1'b0);
      syn_run <= 1'b0;
      repeat (20) @(posedge hclk);
      check(status[2], 1'b1);
      syn_run <= 1'b1;
      in_run <= 1'b0;
      repeat (150) @(posedge hclk);
      check(locked, 1'b1);
      repeat (70) @(posedge hclk);
      check(locked, 1'b0);
      in_run <= 1'b1;
      repeat (40) @(posedge hclk);
      check(locked, 1'b0);
      syn_run <= 1'b0;
      for (i = 0; i < 100 && manager_reset !== 1'b1; i++) @(posedge hclk);
      check(manager_reset, 1'b1);
      syn_run <= 1'b1;
      wait_lock();
      check(phase_value, 8'h20);
      // the unit output is the input clock one cycle late
      check(unit_rate_output, !input_clock);
      // no feedback with unit outputs in use is flagged as a bad setup
      bus(8'h00, 1'b1, 32'h0000_0040, 0);
      bus(8'h10, 1'b0, 0, 32'h0000_0101);
      pulse_reset();
      wait_lock();
      test_done();
   end
endmodule // clock_manager_lock_reset_monitor_bench
`default_nettype wire
